// ---- tmx_regs.svh ----
// Register indices, fields, reset values and timing counts of the test mux
`ifndef TMX_REGS_SVH
`define TMX_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TMX_IDX_W            14
`define TMX_IDX_SEL_A        14'h2502
`define TMX_IDX_SEL_B        14'h2503
`define TMX_IDX_STATUS       14'h2505
`define TMX_IDX_SPARE        14'h2704

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define TMX_SEL_W            5
`define TMX_SPARE_W          8
`define TMX_SPARE_BIT1       1
`define TMX_SPARE_BIT2       2
`define TMX_SEL_RST          5'h00
`define TMX_SPARE_RST        8'h00

// ----------------------------------------------------------------
// Select codes, first pin
// ----------------------------------------------------------------
`define TMX_A_RTC_WAVE       5'h01
`define TMX_A_WD_REFRESH     5'h09
`define TMX_A_CPU_CLK        5'h0A
`define TMX_A_SUPPLY_HIGH    5'h0D
`define TMX_A_SUPPLY_LOW     5'h0E
`define TMX_A_FRAME_SYNC     5'h1B
`define TMX_A_ENGINE_BUSY    5'h1C
`define TMX_A_ENGINE_XFER    5'h1D
`define TMX_A_ENGINE_MONITOR 5'h1F

// ----------------------------------------------------------------
// Select codes, second pin
// ----------------------------------------------------------------
`define TMX_B_WD_EXPIRED     5'h00
`define TMX_B_CALIB_PULSE_ONE_SEC       5'h01
`define TMX_B_CALIB_PULSE_FOUR_SEC       5'h02
`define TMX_B_RTC_WAVE       5'h03
`define TMX_B_SPARE1         5'h08
`define TMX_B_SPARE2         5'h09
`define TMX_B_WAKE           5'h0A
`define TMX_B_FRAME_SYNC     5'h0B
`define TMX_B_MASTER_CLK     5'h0C
`define TMX_B_GROUND         5'h0E

// ----------------------------------------------------------------
// Calibration pulse timing, in real-time-clock periods
// ----------------------------------------------------------------
`define TMX_RTC_CNT_W        17
`define TMX_RTC_CNT_RST      17'h00000

`endif

// ---- tmx_pkg.sv ----
// Types shared by the test signal multiplexer
package tmx_pkg;

    // Asynchronous sources, in order of the synchroniser vector
    typedef struct packed {
        logic rtc_osc_wave;
        logic watchdog_refresh_mark;
        logic processor_clock;
        logic supply_good_high;
        logic supply_good_low;
        logic input_frame_sync;
        logic engine_busy_irq;
        logic engine_transfer_irq;
        logic engine_realtime_monitor;
        logic watchdog_expired;
        logic wake_event;
        logic master_clock;
    } tmx_src_type;

    // Wishbone request as seen by the register file
    typedef struct packed {
        logic        req;
        logic        we;
        logic [13:0] idx;
        logic        lane0;
        logic [7:0]  wdata;
    } tmx_wb_req_type;

endpackage

// ---- tmx_mux.sv ----
// Dual test signal multiplexer with Wishbone register access
`include "tmx_regs.svh"

module tmx_mux
    import tmx_pkg::*;
(
    // Clock and resets
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        bat_por_i,

    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [15:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,

    // Internal sources, asynchronous to clk_i
    input  wire tmx_src_type src_i,

    // Test pins
    output logic             test_out_a_pin_o,
    output logic             test_out_b_pin_o
);

    // ----------------------------------------------------------------
    // Source synchroniser
    // ----------------------------------------------------------------
    tmx_src_type src_meta_q;
    tmx_src_type src_q;

    always_ff @(posedge clk_i)
    begin
        src_meta_q <= src_i;
        src_q      <= src_meta_q;
    end

    // ----------------------------------------------------------------
    // Real-time clock edge counter for calibration pulses
    // ----------------------------------------------------------------
    logic                      rtc_prev_q;
    logic [`TMX_RTC_CNT_W-1:0] rtc_cnt_q;
    logic [`TMX_RTC_CNT_W-1:0] rtc_cnt_d;
    logic                      rtc_rise;
    logic                      calib_pulse_one_sec;
    logic                      calib_pulse_four_sec;

    assign rtc_rise  = src_q.rtc_osc_wave & ~rtc_prev_q;
    assign rtc_cnt_d = rtc_rise
                     ? rtc_cnt_q + `TMX_RTC_CNT_W'(1)
                     : rtc_cnt_q;

    // 32768 periods a second: first quarter of each second is high
    assign calib_pulse_one_sec  = (rtc_cnt_q[14:13] == 2'h0);
    // Four-second window: first quarter of 131072 periods is high
    assign calib_pulse_four_sec  = (rtc_cnt_q[16:15] == 2'h0);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rtc_prev_q <= 1'b0;
            rtc_cnt_q  <= `TMX_RTC_CNT_RST;
        end
        else
        begin
            rtc_prev_q <= src_q.rtc_osc_wave;
            rtc_cnt_q  <= rtc_cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // Wishbone request decode
    // ----------------------------------------------------------------
    tmx_wb_req_type wb;
    logic           wr_en;
    logic           hit_sel_a;
    logic           hit_sel_b;
    logic           hit_spare;
    logic           hit_status;

    assign wb.req   = cyc_i & stb_i & ~ack_o;
    assign wb.we    = we_i;
    assign wb.idx   = adr_i[15:2];
    assign wb.lane0 = sel_i[0];
    assign wb.wdata = dat_i[7:0];

    assign wr_en      = wb.req & wb.we & wb.lane0;
    assign hit_sel_a  = (wb.idx == `TMX_IDX_SEL_A);
    assign hit_sel_b  = (wb.idx == `TMX_IDX_SEL_B);
    assign hit_spare  = (wb.idx == `TMX_IDX_SPARE);
    assign hit_status = (wb.idx == `TMX_IDX_STATUS);

    // ----------------------------------------------------------------
    // Battery-backed select registers
    // ----------------------------------------------------------------
    logic [`TMX_SEL_W-1:0]   sel_a_q;
    logic [`TMX_SEL_W-1:0]   sel_b_q;
    logic [`TMX_SPARE_W-1:0] spare_q;

    // Only battery power-up clears them; rst_i never does
    always_ff @(posedge clk_i)
    begin
        if (bat_por_i)
        begin
            sel_a_q <= `TMX_SEL_RST;
            sel_b_q <= `TMX_SEL_RST;
        end
        else
        begin
            if (wr_en && hit_sel_a)
            begin
                sel_a_q <= wb.wdata[`TMX_SEL_W-1:0];
            end
            if (wr_en && hit_sel_b)
            begin
                sel_b_q <= wb.wdata[`TMX_SEL_W-1:0];
            end
        end
    end

    // Spare bits are ordinary device state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            spare_q <= `TMX_SPARE_RST;
        end
        else if (wr_en && hit_spare)
        begin
            spare_q <= wb.wdata;
        end
    end

    // ----------------------------------------------------------------
    // First pin code decode
    // ----------------------------------------------------------------
    logic a_rtc_wave;
    logic a_wd_refresh;
    logic a_cpu_clk;
    logic a_supply_high;
    logic a_supply_low;
    logic a_frame_sync;
    logic a_engine_busy;
    logic a_engine_xfer;
    logic a_engine_monitor;
    logic a_reserved;

    assign a_rtc_wave       = (sel_a_q == `TMX_A_RTC_WAVE);
    assign a_wd_refresh     = (sel_a_q == `TMX_A_WD_REFRESH);
    assign a_cpu_clk        = (sel_a_q == `TMX_A_CPU_CLK);
    assign a_supply_high    = (sel_a_q == `TMX_A_SUPPLY_HIGH);
    assign a_supply_low     = (sel_a_q == `TMX_A_SUPPLY_LOW);
    assign a_frame_sync     = (sel_a_q == `TMX_A_FRAME_SYNC);
    assign a_engine_busy    = (sel_a_q == `TMX_A_ENGINE_BUSY);
    assign a_engine_xfer    = (sel_a_q == `TMX_A_ENGINE_XFER);
    assign a_engine_monitor = (sel_a_q == `TMX_A_ENGINE_MONITOR);
    assign a_reserved       = ~(a_rtc_wave | a_wd_refresh | a_cpu_clk
                              | a_supply_high | a_supply_low
                              | a_frame_sync | a_engine_busy
                              | a_engine_xfer | a_engine_monitor);

    // ----------------------------------------------------------------
    // First pin selection
    // ----------------------------------------------------------------
    logic mux_a;

    assign mux_a =
        a_reserved    ? 1'b0 :
        a_rtc_wave    ? src_q.rtc_osc_wave :
        a_wd_refresh  ? src_q.watchdog_refresh_mark :
        a_cpu_clk     ? src_q.processor_clock :
        a_supply_high ? src_q.supply_good_high :
        a_supply_low  ? src_q.supply_good_low :
        a_frame_sync  ? src_q.input_frame_sync :
        a_engine_busy ? src_q.engine_busy_irq :
        a_engine_xfer ? src_q.engine_transfer_irq
                      : src_q.engine_realtime_monitor;

    // ----------------------------------------------------------------
    // Second pin code decode
    // ----------------------------------------------------------------
    logic b_wd_expired;
    logic b_calib_pulse_one_sec;
    logic b_calib_pulse_four_sec;
    logic b_rtc_wave;
    logic b_spare1;
    logic b_spare2;
    logic b_wake;
    logic b_frame_sync;
    logic b_master_clk;
    logic b_ground;
    logic b_reserved;

    assign b_wd_expired = (sel_b_q == `TMX_B_WD_EXPIRED);
    assign b_calib_pulse_one_sec   = (sel_b_q == `TMX_B_CALIB_PULSE_ONE_SEC);
    assign b_calib_pulse_four_sec   = (sel_b_q == `TMX_B_CALIB_PULSE_FOUR_SEC);
    assign b_rtc_wave   = (sel_b_q == `TMX_B_RTC_WAVE);
    assign b_spare1     = (sel_b_q == `TMX_B_SPARE1);
    assign b_spare2     = (sel_b_q == `TMX_B_SPARE2);
    assign b_wake       = (sel_b_q == `TMX_B_WAKE);
    assign b_frame_sync = (sel_b_q == `TMX_B_FRAME_SYNC);
    assign b_master_clk = (sel_b_q == `TMX_B_MASTER_CLK);
    assign b_ground     = (sel_b_q == `TMX_B_GROUND);
    assign b_reserved   = ~(b_wd_expired | b_calib_pulse_one_sec | b_calib_pulse_four_sec
                          | b_rtc_wave | b_spare1 | b_spare2 | b_wake
                          | b_frame_sync | b_master_clk
                          | b_ground);

    // ----------------------------------------------------------------
    // Second pin selection
    // ----------------------------------------------------------------
    logic mux_b;

    assign mux_b =
        b_reserved   ? 1'b0 :
        b_wd_expired ? src_q.watchdog_expired :
        b_calib_pulse_one_sec   ? calib_pulse_one_sec :
        b_calib_pulse_four_sec   ? calib_pulse_four_sec :
        b_rtc_wave   ? src_q.rtc_osc_wave :
        b_spare1     ? spare_q[`TMX_SPARE_BIT1] :
        b_spare2     ? spare_q[`TMX_SPARE_BIT2] :
        b_wake       ? src_q.wake_event :
        b_frame_sync ? src_q.input_frame_sync :
        b_master_clk ? src_q.master_clock
                     : 1'b0;

    // ----------------------------------------------------------------
    // Test pin registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            test_out_a_pin_o <= 1'b0;
            test_out_b_pin_o <= 1'b0;
        end
        else
        begin
            test_out_a_pin_o <= mux_a;
            test_out_b_pin_o <= mux_b;
        end
    end

    // ----------------------------------------------------------------
    // Read data selection
    // ----------------------------------------------------------------
    logic [31:0] rd_data;
    logic [31:0] status_word;

    assign status_word = {28'h0000000,
                          calib_pulse_four_sec,
                          calib_pulse_one_sec,
                          test_out_b_pin_o,
                          test_out_a_pin_o};

    assign rd_data =
        hit_sel_a  ? {27'h0000000, sel_a_q} :
        hit_sel_b  ? {27'h0000000, sel_b_q} :
        hit_spare  ? {24'h000000, spare_q} :
        hit_status ? status_word
                   : 32'h00000000;

    // ----------------------------------------------------------------
    // Wishbone answer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end
        else
        begin
            ack_o <= wb.req;
            dat_o <= (wb.req && !wb.we) ? rd_data : 32'h00000000;
        end
    end

endmodule

// ---- tmx_mux_monitor.sv ----
// Checker of the test multiplexer pins and register bus
`include "tmx_regs.svh"
module tmx_mux_monitor
    import tmx_pkg::*;
(
    // Clock, resets and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        bat_por_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [15:0] adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Sources and pins
    input wire tmx_src_type src_i,
    input wire logic        test_out_a_pin_o,
    input wire logic        test_out_b_pin_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [4:0]  sa_q, sb_q;
    logic [7:0]  sp_q;
    logic [1:0]  age_q;
    tmx_src_type s1_q, s2_q, s3_q;
    wire         take = cyc_i & stb_i & ~ack_o;
    wire         wr = take & we_i & sel_i[0];
    wire [13:0]  idx = adr_i[15:2];
    wire [4:0]   sa_d = bat_por_i ? 5'h00
                      : (wr && idx == `TMX_IDX_SEL_A) ? dat_i[4:0] : sa_q;
    wire [4:0]   sb_d = bat_por_i ? 5'h00
                      : (wr && idx == `TMX_IDX_SEL_B) ? dat_i[4:0] : sb_q;
    wire [7:0]   sp_d = rst_i ? 8'h00
                      : (wr && idx == `TMX_IDX_SPARE) ? dat_i[7:0] : sp_q;
    wire [1:0]   age_d = (rst_i | bat_por_i | (take & we_i)) ? 2'h0
                       : (age_q == 2'h3) ? 2'h3 : age_q + 2'h1;
    always_ff @(posedge clk_i)
    begin
        sa_q <= sa_d;
        sb_q <= sb_d;
        sp_q <= sp_d;
        age_q <= age_d;
        s1_q <= src_i;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end
    // ------------------------------------------------------------
    // Expected pin levels
    // ------------------------------------------------------------
    wire ea = (sa_q == 5'h01) ? s3_q.rtc_osc_wave
            : (sa_q == 5'h09) ? s3_q.watchdog_refresh_mark
            : (sa_q == 5'h0A) ? s3_q.processor_clock
            : (sa_q == 5'h0D) ? s3_q.supply_good_high
            : (sa_q == 5'h0E) ? s3_q.supply_good_low
            : (sa_q == 5'h1B) ? s3_q.input_frame_sync
            : (sa_q == 5'h1C) ? s3_q.engine_busy_irq
            : (sa_q == 5'h1D) ? s3_q.engine_transfer_irq
            : (sa_q == 5'h1F) ? s3_q.engine_realtime_monitor : 1'b0;
    wire eb = (sb_q == 5'h00) ? s3_q.watchdog_expired
            : (sb_q == 5'h03) ? s3_q.rtc_osc_wave
            : (sb_q == 5'h08) ? sp_q[1]
            : (sb_q == 5'h09) ? sp_q[2]
            : (sb_q == 5'h0A) ? s3_q.wake_event
            : (sb_q == 5'h0B) ? s3_q.input_frame_sync
            : (sb_q == 5'h0C) ? s3_q.master_clock : 1'b0;
    wire a_on = sa_q inside {1, 9, 10, 13, 14, 27, 28, 29, 31};
    wire b_on = sb_q inside {0, 1, 2, 3, 8, 9, 10, 11, 12, 14};
    wire st = age_q == 2'h3;
    sequence s_take; take; endsequence
    sequence s_ans; ack_o ##1 !ack_o; endsequence
    property p_ack; s_take |=> s_ans; endproperty
    property p_rd_a;
        take && !we_i && idx == `TMX_IDX_SEL_A |=> dat_o == {27'h0, sa_q};
    endproperty
    property p_rd_b;
        take && !we_i && idx == `TMX_IDX_SEL_B |=> dat_o == {27'h0, sb_q};
    endproperty
    property p_a_list; st && a_on |-> test_out_a_pin_o == ea; endproperty
    property p_a_rsv; st && !a_on |-> !test_out_a_pin_o; endproperty
    property p_b_list;
        st && sb_q inside {0, 3, 10, 11, 12} |-> test_out_b_pin_o == eb;
    endproperty
    property p_b_spare;
        st && sb_q inside {8, 9} |-> test_out_b_pin_o == eb;
    endproperty
    property p_b_gnd; st && sb_q == 5'h0E |-> !test_out_b_pin_o; endproperty
    property p_b_rsv; st && !b_on |-> !test_out_b_pin_o; endproperty
    a_ack: assert property (p_ack) else $error("ack pulse wrong");
    a_rd_a: assert property (p_rd_a)
        else $error("first select readback wrong");
    a_rd_b: assert property (p_rd_b)
        else $error("second select readback wrong");
    a_a_list: assert property (p_a_list)
        else $error("first pin source wrong");
    a_a_rsv: assert property (p_a_rsv)
        else $error("first pin not low");
    a_b_list: assert property (p_b_list)
        else $error("second pin source wrong");
    a_b_spare: assert property (p_b_spare)
        else $error("second pin spare wrong");
    a_b_gnd: assert property (p_b_gnd)
        else $error("ground code not low");
    a_b_rsv: assert property (p_b_rsv) else $error("second pin not low");
endmodule
bind tmx_mux tmx_mux_monitor i_tmx_mux_monitor (.clk_i, .rst_i, .bat_por_i,
    .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .src_i,
    .test_out_a_pin_o, .test_out_b_pin_o);

// ---- tmx_tester.sv ----
// Tester model that times the high phases of a test pin
module tmx_tester
(
    // Clock and observed pin
    input  wire logic clk_i,
    input  wire logic pin_i,
    // Last high length in cycles, count of falls
    output int        high_len_o,
    output int        falls_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int run;
    always @(posedge clk_i)
    begin
        if (pin_i === 1'b1)
            run <= run + 1;
        else if (run != 0)
        begin
            high_len_o <= run;
            falls_o <= falls_o + 1;
            run <= 0;
        end
    end
endmodule

// ---- tb_top.sv ----
// Self-checking bench of the dual test signal multiplexer
`include "tmx_regs.svh"
module tb_top
    import tmx_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i, rst_i, bat_por_i, cyc_i, stb_i, we_i, rtc_run;
    logic [15:0] adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic        ack_o, pin_a, pin_b;
    logic        rtc_wave = 1'b0;
    tmx_src_type src_i;
    int          err_count, checked, seed, hi_len, falls, n;
    logic [4:0]  ma, mb;
    logic [7:0]  msp;
    tmx_mux i_tmx_mux (.clk_i, .rst_i, .bat_por_i, .cyc_i, .stb_i, .we_i,
        .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .src_i(src_i ^ {rtc_wave, 11'h000}),
        .test_out_a_pin_o(pin_a), .test_out_b_pin_o(pin_b));
    tmx_tester i_tmx_tester (.clk_i, .pin_i(pin_b), .high_len_o(hi_len),
        .falls_o(falls));
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
        if (rtc_run)
            rtc_wave <= ~rtc_wave;
    // ------------------------------------------------------------
    // Bus cycles, model and comparison
    // ------------------------------------------------------------
    task automatic wb(input logic w, input logic [13:0] ix,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, sel_i} <= {2'h3, w, 4'h1};
        adr_i <= {ix, 2'h0};
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        {cyc_i, stb_i} <= 2'h0;
    endtask
    function automatic logic f_a(logic [4:0] c, tmx_src_type s);
        return c == 5'h01 ? s.rtc_osc_wave : c == 5'h09 ?
            s.watchdog_refresh_mark : c == 5'h0A ? s.processor_clock :
            c == 5'h0D ? s.supply_good_high : c == 5'h0E ? s.supply_good_low
            : c == 5'h1B ? s.input_frame_sync : c == 5'h1C ? s.engine_busy_irq
            : c == 5'h1D ? s.engine_transfer_irq
            : c == 5'h1F ? s.engine_realtime_monitor : 1'b0;
    endfunction
    function automatic logic f_b(logic [4:0] c, tmx_src_type s,
                                 logic [7:0] p);
        return c == 5'h00 ? s.watchdog_expired : c == 5'h03 ? s.rtc_osc_wave
            : c == 5'h08 ? p[1] : c == 5'h09 ? p[2] : c == 5'h0A ?
            s.wake_event : c == 5'h0B ? s.input_frame_sync : c == 5'h0C ?
            s.master_clock : 1'b0;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (100000) @(posedge clk_i);
        err_count++;
        end_sim;
    end
    initial
    begin
        {seed, err_count, checked, rtc_run} = {32'hA2702F7E, 65'h0};
        {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i, src_i} = '0;
        {rst_i, bat_por_i} = 2'h3;
        repeat (12) @(posedge clk_i);
        {rst_i, bat_por_i} <= 2'h0;
        for (int c = 0; c < 32; c++)
        begin
            {ma, mb, msp} = {5'(c), 5'(c) ^ 5'h0C, 8'($random(seed))};
            wb(1'b1, `TMX_IDX_SEL_A, {$random(seed)} & ~32'h1F | c, rd);
            wb(1'b1, `TMX_IDX_SEL_B, {27'h0, mb}, rd);
            wb(1'b1, `TMX_IDX_SPARE, {24'h0, msp}, rd);
            wb(1'b0, `TMX_IDX_SEL_A, 32'h0, rd);
            chk("sel_a", {27'h0, ma}, rd);
            repeat (2)
            begin
                @(posedge clk_i);
                src_i <= 12'($random(seed));
                repeat (5) @(posedge clk_i);
                chk("pin_a", 32'(f_a(ma, src_i)), 32'(pin_a));
                if (mb != 5'h01 && mb != 5'h02)
                    chk("pin_b", 32'(f_b(mb, src_i, msp)), 32'(pin_b));
            end
            wb(1'b0, `TMX_IDX_STATUS, 32'h0, rd);
            chk("stat_a", 32'(f_a(ma, src_i)), 32'(rd[0]));
        end
        wb(1'b0, 14'h0000, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        for (int k = 1; k <= 2; k++)
        begin
            wb(1'b1, `TMX_IDX_SEL_B, 32'(k), rd);
            {src_i, rtc_run, rst_i} <= {12'h0, 2'h3};
            repeat (12) @(posedge clk_i);
            rst_i <= 1'b0;
            n = falls;
            wb(1'b0, `TMX_IDX_SEL_B, 32'h0, rd);
            chk("sel_b_kept", 32'(k), rd);
            for (int t = 0; t < 70000 && falls == n; t++) @(posedge clk_i);
            n = hi_len - 16384 * k * k;
            chk("pulse_high", 32'h1, 32'(n inside {[-8:8]}));
            rtc_run <= 1'b0;
        end
        end_sim;
    end
endmodule
